// >>> logic/periph_request_flags.sv
// Peripheral interrupt request flags behind an AHB-Lite slave
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
`include "irq_flags_defines.svh"
module periph_request_flags
  import irq_flags_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device pins watched for change and external events
  input wire logic [7:0] gpio_pins,
  // One-cycle event pulses from peripherals on hclk
  input wire logic timer0_overflow,
  input wire logic timer1_gate_close,
  input wire logic conversion_done,
  input wire logic sync1_done,
  input wire logic sync1_collision,
  input wire logic timer2_match,
  input wire logic timer1_overflow,
  input wire logic timer6_match,
  input wire logic comparator2_event,
  input wire logic comparator1_event,
  input wire logic nvm_task_done,
  input wire logic sync2_done,
  input wire logic sync2_collision,
  input wire logic timer4_match,
  input wire logic oscillator_rollover,
  // Buffer levels from the asynchronous serial port
  input wire logic async_rx_not_empty,
  input wire logic async_tx_ready,
  // Request to the core
  output logic peripheral_irq
);

  // ===========================================================
  // Helpers
  // ===========================================================

  // Byte lane 0 is touched by this size and address
  function automatic logic lane0_hit(input logic [2:0] size,
                                     input logic [1:0] low);
    case (size)
      3'd0: lane0_hit = (low == 2'd0);
      3'd1: lane0_hit = ~low[1];
      default: lane0_hit = 1'b1;
    endcase
  endfunction : lane0_hit

  // Value a flag byte takes after an optional write
  function automatic flag_byte_t flag_next(input flag_byte_t cur,
                                           input flag_byte_t set,
                                           input logic wr,
                                           input flag_byte_t wdat,
                                           input flag_byte_t mask);
    if (wr) begin
      flag_next = ((wdat & mask) | set) & mask;
    end else begin
      flag_next = (cur | set) & mask;
    end
  endfunction : flag_next

  // A write data phase to the given register word ends this cycle
  function automatic logic word_write(input logic wr,
                                      input logic [7:0] at,
                                      input logic [7:0] ofs);
    word_write = wr & (at == ofs);
  endfunction : word_write

  // ===========================================================
  // Bus slave
  // ===========================================================
  bus_phase_t phase_r;
  logic [7:0] addr_r;
  logic lane0_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic accept;
  logic wr_now;

  assign accept = hsel & hready & htrans[1];
  assign wr_now = (phase_r == PH_WRITE) & lane0_r;

  // Address phase capture; reads take one wait state so the read
  // mux sees any write finished on the edge the read was taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= PH_IDLE;
      addr_r <= 8'h00;
      lane0_r <= 1'b0;
      hreadyout_r <= 1'b1;
    end else begin
      case (phase_r)
        PH_READ: begin
          phase_r <= PH_IDLE;
          hreadyout_r <= 1'b1;
        end
        PH_IDLE, PH_WRITE: begin
          if (accept) begin
            addr_r <= {haddr[7:2], 2'b00};
            lane0_r <= lane0_hit(hsize, haddr[1:0]);
            phase_r <= hwrite ? PH_WRITE : PH_READ;
            hreadyout_r <= hwrite;
          end else begin
            phase_r <= PH_IDLE;
          end
        end
        default: begin
          phase_r <= PH_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  // Only OKAY is ever answered, unmapped words included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  // ===========================================================
  // Pin synchronisers and edge detection
  // ===========================================================
  logic [7:0] pin_sync_r;
  logic [7:0] pin_prev_r;
  logic [7:0] rise_mask_r;
  logic [7:0] fall_mask_r;
  logic [7:0] pin_flags_r;
  logic [2:0] pin_sel_r;
  logic [7:0] control_r;
  logic ext_now;
  logic ext_prev;
  logic ext_edge;

  // One cell per pin: two-stage synchroniser, edge detect and flag.
  // Only the second stage reads the first, so a metastable first
  // stage never reaches the edge logic
  for (genvar gi = 0; gi < 8; gi++) begin : g_pin
    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic flag_r;
    logic edge_set;

    // Synchroniser and the delayed copy for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
        prev_r <= 1'b0;
      end else begin
        meta_r <= gpio_pins[gi];
        sync_r <= meta_r;
        prev_r <= sync_r;
      end
    end

    // Each edge direction passes only through its own enable
    assign edge_set = (sync_r & ~prev_r & rise_mask_r[gi]) |
                      (~sync_r & prev_r & fall_mask_r[gi]);

    // Sticky per-pin flag; an edge in the cycle of a write wins
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_r <= 1'b0;
      end else if (edge_set) begin
        flag_r <= 1'b1;
      end else if (word_write(wr_now, addr_r, `OFS_PIN_FLAGS)) begin
        flag_r <= hwdata[gi];
      end
    end

    // Bits gathered for the external event, summary and read mux
    assign pin_sync_r[gi] = sync_r;
    assign pin_prev_r[gi] = prev_r;
    assign pin_flags_r[gi] = flag_r;
  end : g_pin

  // External event comes from whichever pin is selected
  assign ext_now = pin_sync_r[pin_sel_r];
  assign ext_prev = pin_prev_r[pin_sel_r];
  assign ext_edge = control_r[`CTL_EXT_RISING] ? (ext_now & ~ext_prev)
                                               : (~ext_now & ext_prev);

  // ===========================================================
  // Configuration registers
  // ===========================================================

  // Configuration words below take writes through byte lane 0 only

  // Rising-edge enable per pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_mask_r <= `FLAGS_RESET;
    end else if (word_write(wr_now, addr_r, `OFS_RISE_MASK)) begin
      rise_mask_r <= hwdata[7:0];
    end
  end

  // Falling-edge enable per pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_mask_r <= `FLAGS_RESET;
    end else if (word_write(wr_now, addr_r, `OFS_FALL_MASK)) begin
      fall_mask_r <= hwdata[7:0];
    end
  end

  // Which pin feeds the external event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sel_r <= `SEL_RESET;
    end else if (word_write(wr_now, addr_r, `OFS_PIN_SELECT)) begin
      pin_sel_r <= hwdata[2:0];
    end
  end

  // Peripheral enable, stored global enable and event edge select;
  // unused bits are dropped so they always read back as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_r <= `CTL_RESET;
    end else if (word_write(wr_now, addr_r, `OFS_CONTROL)) begin
      control_r <= hwdata[7:0] & `CTL_MASK;
    end
  end

  // ===========================================================
  // Request flags
  // ===========================================================
  flag_byte_t group0_r;
  flag_byte_t group1_r;
  flag_byte_t group2_r;
  flag_byte_t set0;
  flag_byte_t set1;
  flag_byte_t set2;
  logic rx_level_r;
  logic tx_level_r;
  logic summary;

  // Event pulses gathered by position; no enable is consulted
  always_comb begin
    set0 = 8'h00;
    set1 = 8'h00;
    set2 = 8'h00;
    set0[`G0_TIMER0_OVF] = timer0_overflow;
    set0[`G0_EXT_EVENT] = ext_edge;
    set1[`G1_T1_GATE] = timer1_gate_close;
    set1[`G1_CONV_DONE] = conversion_done;
    set1[`G1_SYNC1_DONE] = sync1_done;
    set1[`G1_SYNC1_COLL] = sync1_collision;
    set1[`G1_T2_MATCH] = timer2_match;
    set1[`G1_T1_OVF] = timer1_overflow;
    set2[`G2_T6_MATCH] = timer6_match;
    set2[`G2_COMP2] = comparator2_event;
    set2[`G2_COMP1] = comparator1_event;
    set2[`G2_NVM_DONE] = nvm_task_done;
    set2[`G2_SYNC2_DONE] = sync2_done;
    set2[`G2_SYNC2_COLL] = sync2_collision;
    set2[`G2_T4_MATCH] = timer4_match;
    set2[`G2_OSC_ROLL] = oscillator_rollover;
  end

  // Sticky flags: hardware sets, software writes; set beats clear so
  // an event landing on a clearing write is never lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      group0_r <= `FLAGS_RESET;
    end else begin
      group0_r <= flag_next(group0_r, set0,
                            word_write(wr_now, addr_r, `OFS_GROUP0),
                            hwdata[7:0], `G0_LATCH_MASK);
    end
  end

  // Group 1 latches six bits; the serial levels are mirrored apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      group1_r <= `FLAGS_RESET;
    end else begin
      group1_r <= flag_next(group1_r, set1,
                            word_write(wr_now, addr_r, `OFS_GROUP1),
                            hwdata[7:0], `G1_LATCH_MASK);
    end
  end

  // Group 2: every bit is a latched event flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      group2_r <= `FLAGS_RESET;
    end else begin
      group2_r <= flag_next(group2_r, set2,
                            word_write(wr_now, addr_r, `OFS_GROUP2),
                            hwdata[7:0], 8'hFF);
    end
  end

  // Serial buffer levels are mirrored, never latched; the level
  // inputs come from hclk logic so one flop is enough
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_level_r <= 1'b0;
      tx_level_r <= 1'b0;
    end else begin
      rx_level_r <= async_rx_not_empty;
      tx_level_r <= async_tx_ready;
    end
  end

  // Summary is live: it drops as soon as the last pin flag clears
  assign summary = |pin_flags_r;

  // ===========================================================
  // Read path and core request
  // ===========================================================
  logic [7:0] rd_byte;

  // Read mux; unimplemented bits and unmapped words read zero
  always_comb begin
    rd_byte = 8'h00;
    case (addr_r)
      `OFS_GROUP0: begin
        rd_byte = group0_r;
        rd_byte[`G0_PIN_SUMMARY] = summary;
      end
      `OFS_GROUP1: begin
        rd_byte = group1_r;
        rd_byte[`G1_RX_PENDING] = rx_level_r;
        rd_byte[`G1_TX_REQUEST] = tx_level_r;
      end
      `OFS_GROUP2: rd_byte = group2_r;
      `OFS_CONTROL: rd_byte = control_r;
      `OFS_RISE_MASK: rd_byte = rise_mask_r;
      `OFS_FALL_MASK: rd_byte = fall_mask_r;
      `OFS_PIN_FLAGS: rd_byte = pin_flags_r;
      `OFS_PIN_SELECT: rd_byte = {5'b00000, pin_sel_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data loads in the wait cycle and then holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (phase_r == PH_READ) begin
      hrdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // The core sees nothing until the peripheral enable is set;
  // any pending flag then asserts the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_irq <= 1'b0;
    end else begin
      peripheral_irq <= control_r[`CTL_PERIPH_EN] &
                        (|group0_r | summary | |group1_r |
                         rx_level_r | tx_level_r | |group2_r);
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;

endmodule : periph_request_flags
`default_nettype wire

// >>> shared/irq_flags_defines.svh
// Register map, field positions and reset values of the request flag block
//
// Summary of operation
// - Timer0 overflow sets group0 bit 5, sticky
// - Group0 bit 4 reads OR of pin flags
// - Pin edges masked by rising/falling masks
// - External pin event sets group0 bit 0
// - External event pin chosen by select register
// - Group0 bits 7-6, 3-1 read zero
// - Flags set regardless of any enable bit
// - All implemented flags reset to zero
// - Timer1 gate close sets group1 bit 7
// - Conversion done sets group1 bit 6
// - Group1 bit 5 follows receive buffer level
// - Group1 bit 4 follows transmit request level
// - Sync port done sets bit 3, sticky
// - Sync port collision sets bit 2, sticky
// - Period matches set their flags, sticky
// - Timer1 overflow sets group1 bit 0
// - Comparators 2 and 1 set bits 6, 5
// - Nonvolatile task done sets group2 bit 4
// - Oscillator rollover sets group2 bit 0
// - Request reaches core only with peripheral enable
`ifndef IRQ_FLAGS_DEFINES_SVH
`define IRQ_FLAGS_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_GROUP0 8'h00
`define OFS_GROUP1 8'h04
`define OFS_GROUP2 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_RISE_MASK 8'h10
`define OFS_FALL_MASK 8'h14
`define OFS_PIN_FLAGS 8'h18
`define OFS_PIN_SELECT 8'h1C

// Group 0 fields
`define G0_TIMER0_OVF 5
`define G0_PIN_SUMMARY 4
`define G0_EXT_EVENT 0
`define G0_LATCH_MASK 8'h21

// Group 1 fields
`define G1_T1_GATE 7
`define G1_CONV_DONE 6
`define G1_RX_PENDING 5
`define G1_TX_REQUEST 4
`define G1_SYNC1_DONE 3
`define G1_SYNC1_COLL 2
`define G1_T2_MATCH 1
`define G1_T1_OVF 0
`define G1_LATCH_MASK 8'hCF

// Group 2 fields
`define G2_T6_MATCH 7
`define G2_COMP2 6
`define G2_COMP1 5
`define G2_NVM_DONE 4
`define G2_SYNC2_DONE 3
`define G2_SYNC2_COLL 2
`define G2_T4_MATCH 1
`define G2_OSC_ROLL 0

// Control register fields
`define CTL_GLOBAL_EN 7
`define CTL_PERIPH_EN 6
`define CTL_EXT_RISING 0
`define CTL_MASK 8'hC1

// Reset values
`define FLAGS_RESET 8'h00
`define CTL_RESET 8'h01
`define SEL_RESET 3'h0

`endif

// >>> shared/irq_flags_pkg.sv
// Types shared by the request flag block
`default_nettype none
package irq_flags_pkg;
  // Phase of the bus transfer in progress
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } bus_phase_t;
  typedef logic [7:0] flag_byte_t;
endpackage : irq_flags_pkg
`default_nettype wire

// >>> dv/periph_events_model.sv
// Model of the peripherals that raise events, drive pins and levels
`default_nettype none
module periph_events_model (
  // Clock
  input wire logic hclk,
  // Event pulses, device pins and serial buffer levels
  output logic [16:0] ev,
  output logic [7:0] pins,
  output logic rx,
  output logic tx
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====================
  // Idle until told otherwise
  initial begin
    {ev, pins, rx, tx} = '0;
  end
  // One-cycle pulse, launched just after an edge as a real peripheral does
  task automatic pulse(input int i);
    @(posedge hclk);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev <= '0;
  endtask : pulse
  // Pins and buffer levels move only just after an edge
  task automatic lvl(input logic [7:0] p, input logic r, input logic t);
    @(posedge hclk);
    pins <= p;
    rx <= r;
    tx <= t;
  endtask : lvl
endmodule : periph_events_model
`default_nettype wire

// >>> dv/periph_request_flags_props.sv
// Bus timing and request gating checks for the request flag block
`default_nettype none
module periph_request_flags_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Event and request
  input wire logic timer0_overflow,
  input wire logic peripheral_irq
);
  logic ctl_wr_r;
  logic en_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // =====================
  // Shadow of the peripheral enable, so the request gate can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_wr_r <= 1'b0;
      en_r <= 1'b0;
    end else begin
      ctl_wr_r <= hsel && hready && htrans[1] && hwrite
        && haddr[7:0] == 8'h0C;
      if (ctl_wr_r) begin
        en_r <= hwdata[6];
      end
    end
  end
  sequence s_take;
    hsel && hready && htrans[1];
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_take ##0 !hwrite |=> s_rd_answer;
  endproperty
  property p_wr_nowait;
    s_take ##0 hwrite |=> hreadyout;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_hold;
    !$stable(hrdata) |-> $past(hreadyout) == 1'b0;
  endproperty
  property p_g0_unused;
    s_take ##0 (!hwrite && haddr[7:0] == 8'h00)
      |=> ##1 (hrdata[7:0] & 8'hCE) == 8'h00;
  endproperty
  property p_irq_gate;
    !en_r |=> !peripheral_irq;
  endproperty
  property p_irq_set;
    (en_r && timer0_overflow) ##1 en_r |=> peripheral_irq;
  endproperty
  property p_reset_quiet;
    $rose(hresetn) |-> hrdata == 32'h0000_0000 && !peripheral_irq;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("error response");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_g0_unused: assert property (p_g0_unused)
    else $error("unused bits set");
  a_irq_gate: assert property (p_irq_gate)
    else $error("request while disabled");
  a_irq_set: assert property (p_irq_set)
    else $error("request not raised");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not clear after reset");
endmodule : periph_request_flags_props
bind periph_request_flags periph_request_flags_props props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .timer0_overflow(timer0_overflow), .peripheral_irq(peripheral_irq));
`default_nettype wire

// >>> dv/periph_request_flags_test.sv
// Self-checking bench for the peripheral request flag block
`default_nettype none
module periph_request_flags_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic hreadyout, hresp, irq, rx, tx;
  logic [16:0] ev;
  logic [7:0] pins;
  int bad_count;
  int samples_checked;
  // =====================
  periph_request_flags dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .gpio_pins(pins), .timer0_overflow(ev[16]),
    .timer1_gate_close(ev[15]), .conversion_done(ev[14]),
    .sync1_done(ev[11]), .sync1_collision(ev[10]),
    .timer2_match(ev[9]), .timer1_overflow(ev[8]),
    .timer6_match(ev[7]), .comparator2_event(ev[6]),
    .comparator1_event(ev[5]), .nvm_task_done(ev[4]),
    .sync2_done(ev[3]), .sync2_collision(ev[2]),
    .timer4_match(ev[1]), .oscillator_rollover(ev[0]),
    .async_rx_not_empty(rx), .async_tx_ready(tx), .peripheral_irq(irq));
  periph_events_model peri (.hclk(hclk), .ev(ev), .pins(pins), .rx(rx),
    .tx(tx));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Single word transfer; the slave decides how long each phase lasts
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= 32'(a);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : xfer
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), rdat, e);
  endtask : rc
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    bad_count++;
    test_done();
  end
  // =====================
  // Main sequence
  initial begin
    logic [7:0] ga;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    hresetn = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rc(8'(4 * i), (i == 3) ? 32'h0000_0001 : 32'h0000_0000);
    end
    xfer(1'b1, 8'h00, 32'h0000_00FF);
    rc(8'h00, 32'h0000_0021);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    xfer(1'b1, 8'h20, 32'h0000_00FF);
    rc(8'h20, 32'h0000_0000);
    // Every event source, then a clearing write of zero
    for (int i = 0; i < 17; i++) begin
      if (i == 12 || i == 13) continue;
      ga = (i > 15) ? 8'h00 : (i > 7) ? 8'h04 : 8'h08;
      peri.pulse(i);
      rc(ga, (i > 15) ? 32'h0000_0020 : 32'(1) << (i % 8));
      xfer(1'b1, ga, 32'h0000_0000);
      rc(ga, 32'h0000_0000);
    end
    // Serial buffer levels are mirrored, not latched
    peri.lvl(8'h00, 1'b1, 1'b0);
    rc(8'h04, 32'h0000_0020);
    peri.lvl(8'h00, 1'b0, 1'b1);
    xfer(1'b1, 8'h04, 32'h0000_0000);
    rc(8'h04, 32'h0000_0010);
    peri.lvl(8'h00, 1'b0, 1'b0);
    rc(8'h04, 32'h0000_0000);
    // Pin 0 rising is enabled; it also feeds the external event
    xfer(1'b1, 8'h10, 32'h0000_0001);
    peri.lvl(8'h01, 1'b0, 1'b0);
    repeat (5) @(posedge hclk);
    rc(8'h18, 32'h0000_0001);
    rc(8'h00, 32'h0000_0011);
    peri.lvl(8'h00, 1'b0, 1'b0);
    xfer(1'b1, 8'h18, 32'h0000_0000);
    repeat (5) @(posedge hclk);
    rc(8'h18, 32'h0000_0000);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    rc(8'h00, 32'h0000_0000);
    // External event moved to pin 2, which has no change mask
    xfer(1'b1, 8'h1C, 32'h0000_0002);
    peri.lvl(8'h04, 1'b0, 1'b0);
    repeat (5) @(posedge hclk);
    rc(8'h00, 32'h0000_0001);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    // Falling edges: pin 2 mask on and the event edge select low
    xfer(1'b1, 8'h14, 32'h0000_0004);
    xfer(1'b1, 8'h0C, 32'h0000_0000);
    peri.lvl(8'h00, 1'b0, 1'b0);
    repeat (5) @(posedge hclk);
    rc(8'h18, 32'h0000_0004);
    rc(8'h00, 32'h0000_0011);
    xfer(1'b1, 8'h18, 32'h0000_0000);
    // A hardware set in the cycle of a clearing write wins
    fork
      peri.pulse(16);
      xfer(1'b1, 8'h00, 32'h0000_0000);
    join
    rc(8'h00, 32'h0000_0020);
    xfer(1'b1, 8'h00, 32'h0000_0000);
    // Request to the core only with the peripheral enable set
    peri.pulse(14);
    repeat (2) @(posedge hclk);
    chk("irq", 32'(irq), 32'h0000_0000);
    rc(8'h04, 32'h0000_0040);
    xfer(1'b1, 8'h04, 32'h0000_0000);
    xfer(1'b1, 8'h0C, 32'h0000_0041);
    peri.pulse(16);
    repeat (2) @(posedge hclk);
    chk("irq", 32'(irq), 32'h0000_0001);
    // Reset in mid-run clears the flags again
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(8'h00, 32'h0000_0000);
    // A byte write that misses lane 0 must leave control alone
    hsize <= 3'b000;
    xfer(1'b1, 8'h0D, 32'h0000_FF00);
    hsize <= 3'b010;
    rc(8'h0C, 32'h0000_0001);
    chk("irq", 32'(irq), 32'h0000_0000);
    test_done();
  end
endmodule : periph_request_flags_test
`default_nettype wire
